// File: hdl/sdcpi_cmd_decode.sv
/*
  Combinational command encoder: maps an operation and address to the
  strobe, select and mask levels of one SDRAM command cycle.
  Assumes the caller registers the result before it reaches the pins.
*/
`timescale 1ns/100ps
`default_nettype none
module sdcpi_cmd_decode
  import sdcpi_pkg::*;
(
  input wire sdcpi_req_t i_req,
  input wire logic i_bus32,
  output sdcpi_pins_t o_pins
);

  // ***********************************************************
  // Decode
  // ***********************************************************
  logic in_space;
  logic [2:0] code;
  logic is_write;
  logic is_col;

  // Reserved sub-spaces inside the SDRAM window select a bank only for refresh.
  assign in_space = (i_req.addr[SDCPI_SPACE_HI:SDCPI_SPACE_LO] == SDCPI_SPACE_SDRAM)
                    && !i_req.addr[SDCPI_RSVD_BIT];
  assign is_write = (i_req.op == 3'(SDCPI_OP_WRITE));
  assign is_col = (code == SDCPI_CMD_READ) || (code == SDCPI_CMD_WRITE);

  // Standard single data rate truth table.
  always_comb begin
    unique case (i_req.op)
      3'(SDCPI_OP_ACT): code = SDCPI_CMD_ACT;
      3'(SDCPI_OP_READ): code = SDCPI_CMD_READ;
      3'(SDCPI_OP_WRITE): code = SDCPI_CMD_WRITE;
      3'(SDCPI_OP_PRE): code = SDCPI_CMD_PRE;
      3'(SDCPI_OP_REF): code = SDCPI_CMD_REF;
      3'(SDCPI_OP_SREF): code = SDCPI_CMD_REF;
      3'(SDCPI_OP_MRS): code = SDCPI_CMD_MRS;
      default: code = SDCPI_CMD_NOP;
    endcase
  end

  // Refresh needs no address, so it is sent even outside the window.
  always_comb begin
    o_pins.bank_select_n = SDCPI_BANK_IDLE;
    if ((in_space && code != SDCPI_CMD_NOP) || code == SDCPI_CMD_REF) begin
      o_pins.bank_select_n[i_req.addr[SDCPI_BANK_HI:SDCPI_BANK_LO]] = 1'b0;
    end
    o_pins.row_strobe_n = code[2];
    o_pins.col_strobe_n = code[1];
    o_pins.sdram_write_strobe_n = code[0];
    // Masks only carry meaning with the column strobe; reads keep them low.
    o_pins.low_word_data_mask = is_col && is_write && !i_bus32 && i_req.addr[0];
    o_pins.high_word_data_mask = is_col && is_write
                                 && (i_bus32 || (i_req.single_word && !i_req.addr[0]));
    o_pins.dedicated_addr_bit10 = i_req.addr[SDCPI_A10_BIT];
    if (!in_space && code != SDCPI_CMD_REF) begin
      o_pins.row_strobe_n = 1'b1;
      o_pins.col_strobe_n = 1'b1;
      o_pins.sdram_write_strobe_n = 1'b1;
      // A refused write must not leave a mask up without its column strobe.
      o_pins.low_word_data_mask = 1'b0;
      o_pins.high_word_data_mask = 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: hdl/sdcpi_pkg.sv
/*
  Package for the SDRAM command pin interface: command codes, address
  window decode constants and the pin bundle carried to the top module.
  Assumes a single 250 MHz system clock domain.
*/
package sdcpi_pkg;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  localparam logic [1:0] SDCPI_SPACE_SDRAM = 2'h1;
  localparam int SDCPI_SPACE_HI = 31;
  localparam int SDCPI_SPACE_LO = 30;
  localparam int SDCPI_BANK_HI = 29;
  localparam int SDCPI_BANK_LO = 28;
  localparam int SDCPI_RSVD_BIT = 27;
  localparam int SDCPI_A10_BIT = 10;

  // ***********************************************************
  // Command codes, {row, column, write} strobes, active low
  // ***********************************************************
  localparam logic [2:0] SDCPI_CMD_NOP = 3'h7;
  localparam logic [2:0] SDCPI_CMD_ACT = 3'h3;
  localparam logic [2:0] SDCPI_CMD_READ = 3'h5;
  localparam logic [2:0] SDCPI_CMD_WRITE = 3'h4;
  localparam logic [2:0] SDCPI_CMD_PRE = 3'h2;
  localparam logic [2:0] SDCPI_CMD_REF = 3'h1;
  localparam logic [2:0] SDCPI_CMD_MRS = 3'h0;

  // ***********************************************************
  // Reset values of the pins
  // ***********************************************************
  localparam logic [3:0] SDCPI_BANK_IDLE = 4'hf;
  localparam logic [3:0] SDCPI_OE_OFF = 4'hf;
  localparam logic SDCPI_CKE_RST = 1'h1;

  typedef enum {
    SDCPI_OP_NOP,
    SDCPI_OP_ACT,
    SDCPI_OP_READ,
    SDCPI_OP_WRITE,
    SDCPI_OP_PRE,
    SDCPI_OP_REF,
    SDCPI_OP_MRS,
    SDCPI_OP_SREF
  } sdcpi_op_t;

  // Command request from the controller core.
  typedef struct packed {
    logic [2:0] op;
    logic [31:0] addr;
    logic single_word;
  } sdcpi_req_t;

  // Registered pin values, active low strobes.
  typedef struct packed {
    logic [3:0] bank_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic sdram_write_strobe_n;
    logic low_word_data_mask;
    logic high_word_data_mask;
    logic dedicated_addr_bit10;
  } sdcpi_pins_t;

endpackage

// File: hdl/sdcpi_top.sv
/*
  SDRAM command pin interface top: registers each command onto the pins,
  drives them only while this device owns the bus, and parks the SDRAM in
  self-refresh with its pins released before a host takes the bus.
  Assumes inputs synchronous to i_clk_sys and an external arbiter.
*/
`timescale 1ns/100ps
`default_nettype none
module sdcpi_top
  import sdcpi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire sdcpi_req_t i_req,
  input wire logic i_req_valid,
  input wire logic i_bus_owner,
  input wire logic i_bus32,
  input wire logic i_suspend,
  input wire logic i_host_bus_request,
  input wire logic i_sdram_clk_enable,
  output sdcpi_pins_t o_pins,
  output logic [3:0] o_bank_oe_n,
  output logic o_ctrl_oe_n,
  output logic o_sdram_clk_enable,
  output logic o_sdram_clk_enable_oe_n,
  output logic o_host_bus_grant,
  output logic o_self_refresh,
  output logic o_req_ready
);

  // ***********************************************************
  // Host handover sequencer
  // ***********************************************************
  typedef enum {
    SDCPI_ST_RUN,
    SDCPI_ST_SREF,
    SDCPI_ST_PARK,
    SDCPI_ST_GRANT
  } sdcpi_state_t;

  sdcpi_state_t state;
  sdcpi_state_t next_state;
  sdcpi_req_t core_req;
  sdcpi_pins_t next_pins;
  logic drive;
  logic unused_cke_in;

  // Clock enable is two-way only for slaves watching it; not needed here.
  assign unused_cke_in = i_sdram_clk_enable;

  // The sequencer injects the self-refresh entry command itself.
  always_comb begin
    core_req = i_req;
    if (state == SDCPI_ST_SREF) begin
      core_req.op = 3'(SDCPI_OP_SREF);
    end else if (!i_req_valid || state != SDCPI_ST_RUN || !i_bus_owner) begin
      core_req.op = 3'(SDCPI_OP_NOP);
    end
  end

  sdcpi_cmd_decode u_decode (
    .i_req(core_req),
    .i_bus32(i_bus32),
    .o_pins(next_pins)
  );

  // A host request first puts the SDRAM to sleep, then releases the pins.
  always_comb begin
    next_state = state;
    unique case (state)
      SDCPI_ST_RUN: if (i_host_bus_request && i_bus_owner) next_state = SDCPI_ST_SREF;
      SDCPI_ST_SREF: next_state = SDCPI_ST_PARK;
      SDCPI_ST_PARK: next_state = SDCPI_ST_GRANT;
      SDCPI_ST_GRANT: if (!i_host_bus_request) next_state = SDCPI_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= SDCPI_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ***********************************************************
  // Registered pins and enables
  // ***********************************************************
  // Pins are driven only while owning the bus and not handed to the host.
  assign drive = i_bus_owner && (state == SDCPI_ST_RUN || state == SDCPI_ST_SREF);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pins.bank_select_n <= SDCPI_BANK_IDLE;
      o_pins.row_strobe_n <= 1'b1;
      o_pins.col_strobe_n <= 1'b1;
      o_pins.sdram_write_strobe_n <= 1'b1;
      o_pins.low_word_data_mask <= 1'b0;
      o_pins.high_word_data_mask <= 1'b0;
      o_pins.dedicated_addr_bit10 <= 1'b0;
      o_bank_oe_n <= SDCPI_OE_OFF;
      o_ctrl_oe_n <= 1'b1;
    end else begin
      o_pins <= next_pins;
      o_bank_oe_n <= drive ? 4'h0 : SDCPI_OE_OFF;
      o_ctrl_oe_n <= !drive;
    end
  end

  // Self-refresh holds the clock enable low until the host hands back.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_self_refresh <= 1'b0;
      o_sdram_clk_enable <= SDCPI_CKE_RST;
      o_sdram_clk_enable_oe_n <= 1'b1;
      o_host_bus_grant <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      if (state == SDCPI_ST_SREF) begin
        o_self_refresh <= 1'b1;
      end else if (state == SDCPI_ST_GRANT && !i_host_bus_request) begin
        o_self_refresh <= 1'b0;
      end
      o_sdram_clk_enable <= !(state == SDCPI_ST_SREF || o_self_refresh || i_suspend);
      o_sdram_clk_enable_oe_n <= !(i_bus_owner && state != SDCPI_ST_GRANT);
      o_host_bus_grant <= (state == SDCPI_ST_GRANT) && i_host_bus_request;
      o_req_ready <= i_bus_owner && state == SDCPI_ST_RUN && !i_host_bus_request;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  sequence s_host_ask;
    i_host_bus_request && i_bus_owner && state == SDCPI_ST_RUN;
  endsequence

  sequence s_sleep_then_park;
    (!o_pins.row_strobe_n && !o_pins.col_strobe_n && o_pins.sdram_write_strobe_n)
      ##1 !o_sdram_clk_enable;
  endsequence

  a_release_sleep: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_host_ask ##1 i_host_bus_request |=> s_sleep_then_park)
    else $error("Self-refresh not entered before release.");

  a_grant_tristate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_host_bus_grant |-> o_ctrl_oe_n && o_bank_oe_n == SDCPI_OE_OFF)
    else $error("Pins driven while host holds the bus.");

  a_cke_sleep_grant: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_host_bus_grant |-> !o_sdram_clk_enable && o_self_refresh)
    else $error("Clock enable high at host grant after self-refresh.");

  a_owner_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_bus_owner) |-> o_bank_oe_n == SDCPI_OE_OFF)
    else $error("Non-owner drives bank selects.");

  a_read_masks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!o_pins.col_strobe_n && o_pins.sdram_write_strobe_n)
      |-> !o_pins.low_word_data_mask && !o_pins.high_word_data_mask)
    else $error("Mask active on read.");

  a_mask_with_col: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_pins.low_word_data_mask || o_pins.high_word_data_mask) |-> !o_pins.col_strobe_n)
    else $error("Mask without column strobe.");

  a_narrow_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($past(i_bus32) && o_pins.row_strobe_n && !o_pins.col_strobe_n
      && !o_pins.sdram_write_strobe_n)
      |-> o_pins.high_word_data_mask && !o_pins.low_word_data_mask)
    else $error("Narrow bus write masks wrong.");

  a_bank_decode: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_req_valid && i_bus_owner && state == SDCPI_ST_RUN && i_req.op == 3'(SDCPI_OP_ACT)
      && i_req.addr[31:30] == 2'h1 && !i_req.addr[SDCPI_RSVD_BIT])
      |=> $countones(~o_pins.bank_select_n) == 1 && !o_pins.row_strobe_n)
    else $error("Bank select missing on SDRAM command.");

  a_write_code: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_req_valid && i_bus_owner && state == SDCPI_ST_RUN && i_req.op == 3'(SDCPI_OP_WRITE)
      && i_req.addr[31:30] == 2'h1 && !i_req.addr[SDCPI_RSVD_BIT])
      |=> o_pins.row_strobe_n && !o_pins.col_strobe_n && !o_pins.sdram_write_strobe_n)
    else $error("Write command code wrong.");

  // Checks on the sleep and release path, the masks and the bank selects. All but a_park_release hold in every state, so a
  // sequencer that skips a step trips one of them at once.
  a_sleep_cke_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_self_refresh |-> !o_sdram_clk_enable)
    else $error("Clock enable high during self-refresh.");

  a_grant_cke_free: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_host_bus_grant |-> o_sdram_clk_enable_oe_n)
    else $error("Clock enable still driven at host grant.");

  a_park_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SDCPI_ST_PARK |=> o_ctrl_oe_n && o_bank_oe_n == SDCPI_OE_OFF)
    else $error("Pins still driven after self-refresh entry.");

  a_wide_low_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_pins.low_word_data_mask |-> !$past(i_bus32))
    else $error("Low mask set on narrow bus.");

  a_one_bank: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $countones(~o_pins.bank_select_n) <= 1)
    else $error("More than one bank select active.");

  // Ready is only a hint, but it must never be offered without owning the pins.
  a_ready_owner: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_req_ready |-> o_bank_oe_n == 4'h0)
    else $error("Ready while bank selects released.");

endmodule
`default_nettype wire

// File: verification/sdcpi_sdram_model.sv
/*
  Behavioural SDRAM seen from its command pins: decodes each driven
  command cycle and keeps the last command code and a command count.
  Assumes the pins are registered on i_clk_sys by the controller.
*/
`timescale 1ns/100ps
`default_nettype none
module sdcpi_sdram_model
  import sdcpi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire sdcpi_pins_t i_pins,
  input wire logic i_ctrl_oe_n,
  output logic [2:0] o_last_cmd,
  output logic [7:0] o_cmd_count
);
  logic [2:0] cmd;

  // Strobes form the command code; a released bus carries no command.
  assign cmd = {i_pins.row_strobe_n, i_pins.col_strobe_n, i_pins.sdram_write_strobe_n};

  // Latch every command other than NOP.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_last_cmd <= 3'h7;
      o_cmd_count <= 8'h00;
    end else if (!i_ctrl_oe_n && cmd != 3'h7) begin
      o_last_cmd <= cmd;
      o_cmd_count <= o_cmd_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench for the SDRAM command pin interface.
  Assumes one 250 MHz clock and the pull levels of the clock enable pin.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sdcpi_pkg::*;
  logic i_clk_sys, i_rst, i_req_valid, i_bus_owner, i_bus32, i_suspend;
  logic i_host_bus_request;
  sdcpi_req_t i_req;
  sdcpi_pins_t o_pins;
  logic [3:0] o_bank_oe_n;
  logic o_ctrl_oe_n, o_sdram_clk_enable, o_sdram_clk_enable_oe_n;
  logic o_host_bus_grant, o_self_refresh, o_req_ready;
  wire logic i_sdram_clk_enable;
  logic [2:0] last_cmd;
  logic [7:0] cnt;
  logic [2:0] mon;
  int errors, checks;

  // ****
  // Pin level and monitors
  // ****
  // A released clock enable follows its pull: down in self-refresh, up otherwise.
  assign i_sdram_clk_enable = !o_sdram_clk_enable_oe_n ? o_sdram_clk_enable : !o_self_refresh;
  assign mon = {o_sdram_clk_enable, i_sdram_clk_enable, o_host_bus_grant};

  sdcpi_top sdcpi_top_i (.i_clk_sys, .i_rst, .i_req, .i_req_valid, .i_bus_owner,
    .i_bus32, .i_suspend, .i_host_bus_request, .i_sdram_clk_enable, .o_pins,
    .o_bank_oe_n, .o_ctrl_oe_n, .o_sdram_clk_enable, .o_sdram_clk_enable_oe_n,
    .o_host_bus_grant, .o_self_refresh, .o_req_ready);
  sdcpi_sdram_model sdcpi_sdram_model_i (.i_clk_sys, .i_rst, .i_pins(o_pins),
    .i_ctrl_oe_n(o_ctrl_oe_n), .o_last_cmd(last_cmd), .o_cmd_count(cnt));

  // Free-running clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ****
  // Tasks
  // ****
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // Bounded wait on one monitored level; a timeout ends the run.
  task automatic waitv(input int s, input logic v);
    int n;
    n = 0;
    while (mon[s] !== v && n < 50) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (mon[s] !== v) begin
      chk("wait", {7'h0, v}, {7'h0, mon[s]});
      finish_test();
    end
  endtask

  // One command cycle; the pins answer on the same edge that takes it.
  task automatic cmd(input logic [2:0] op, input logic [31:0] a, input logic sw);
    @(posedge i_clk_sys);
    i_req <= '{op, a, sw};
    i_req_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b0;
    #1;
  endtask

  task automatic pins(input logic [2:0] c, input logic [3:0] b, input logic [1:0] m);
    chk("cmd", {5'h0, c}, {5'h0, o_pins.row_strobe_n, o_pins.col_strobe_n,
      o_pins.sdram_write_strobe_n});
    chk("bank", {4'h0, b}, {4'h0, o_pins.bank_select_n});
    chk("mask", {6'h0, m}, {6'h0, o_pins.low_word_data_mask, o_pins.high_word_data_mask});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic test_table();
    logic [2:0] ex [6] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    logic [7:0] c0;
    c0 = cnt;
    for (int i = 0; i < 6; i++) begin
      cmd(3'(i + 1), 32'h5000_0000, 1'b1);
      pins(ex[i], 4'hd, (i == 2) ? 2'h1 : 2'h0);
    end
    #4;
    chk("count", c0 + 8'h06, cnt);
    $display("test table done");
  endtask

  task automatic test_masks();
    cmd(3'h3, 32'h4000_0001, 1'b1);
    pins(3'h4, 4'he, 2'h2);
    cmd(3'h3, 32'h4000_0002, 1'b0);
    pins(3'h4, 4'he, 2'h0);
    cmd(3'h2, 32'h4000_0001, 1'b1);
    pins(3'h5, 4'he, 2'h0);
    @(posedge i_clk_sys);
    i_bus32 <= 1'b1;
    cmd(3'h3, 32'h4000_0000, 1'b0);
    pins(3'h4, 4'he, 2'h1);
    @(posedge i_clk_sys);
    i_bus32 <= 1'b0;
    cmd(3'h4, 32'h7000_0400, 1'b0);
    chk("a10", 8'h1, {7'h0, o_pins.dedicated_addr_bit10});
    $display("test masks done");
  endtask

  task automatic test_refuse();
    cmd(3'h2, 32'h8000_0000, 1'b1);
    pins(3'h7, 4'hf, 2'h0);
    cmd(3'h2, 32'h4800_0000, 1'b1);
    pins(3'h7, 4'hf, 2'h0);
    @(posedge i_clk_sys);
    i_bus_owner <= 1'b0;
    cmd(3'h2, 32'h4000_0000, 1'b1);
    #4;
    chk("bank_oe", 8'hf, {4'h0, o_bank_oe_n});
    chk("ready", 8'h0, {7'h0, o_req_ready});
    @(posedge i_clk_sys);
    i_bus_owner <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("bank_oe", 8'h0, {4'h0, o_bank_oe_n});
    chk("ready", 8'h1, {7'h0, o_req_ready});
    $display("test refuse done");
  endtask

  task automatic test_host();
    @(posedge i_clk_sys);
    i_host_bus_request <= 1'b1;
    waitv(0, 1'b1);
    chk("sref", 8'h1, {7'h0, o_self_refresh});
    chk("cke", 8'h0, {7'h0, i_sdram_clk_enable});
    chk("oe", 8'h3f, {o_bank_oe_n, o_ctrl_oe_n, o_sdram_clk_enable_oe_n});
    chk("last", 8'h1, {5'h0, last_cmd});
    chk("ready", 8'h0, {7'h0, o_req_ready});
    @(posedge i_clk_sys);
    i_host_bus_request <= 1'b0;
    waitv(1, 1'b1);
    chk("grant", 8'h0, {7'h0, o_host_bus_grant});
    chk("sref", 8'h0, {7'h0, o_self_refresh});
    $display("test host done");
  endtask

  task automatic test_suspend();
    @(posedge i_clk_sys);
    i_suspend <= 1'b1;
    waitv(2, 1'b0);
    @(posedge i_clk_sys);
    i_suspend <= 1'b0;
    waitv(2, 1'b1);
    chk("cke", 8'h1, {7'h0, o_sdram_clk_enable});
    $display("test suspend done");
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    errors = 0;
    checks = 0;
    i_rst = 1'b1;
    i_req = '0;
    i_req_valid = 1'b0;
    i_bus_owner = 1'b1;
    i_bus32 = 1'b0;
    i_suspend = 1'b0;
    i_host_bus_request = 1'b0;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk("cke_rst", 8'h1, {7'h0, o_sdram_clk_enable});
    test_table();
    test_masks();
    test_refuse();
    test_host();
    test_suspend();
    finish_test();
  end
endmodule
`default_nettype wire
